// ---- ser_pkg.sv ----
// Package with register map, field layouts and constants of the status event block.
package ser_pkg;
  localparam int unsigned WIDTH = 16;
  localparam int unsigned NGRP = 4;
  localparam int unsigned NCHAN = 2;
  localparam int unsigned QDEPTH = 8;
  localparam int unsigned ERRW = 16;
  // Group indices; channel groups follow the two top-level groups.
  localparam logic [1:0] GRP_OPER = 2'h0;
  localparam logic [1:0] GRP_QUES = 2'h1;
  // Word offsets: group select in addr[7:5], part in addr[4:2].
  localparam logic [2:0] PART_COND = 3'h0;
  localparam logic [2:0] PART_EVENT = 3'h1;
  localparam logic [2:0] PART_ENABLE = 3'h2;
  localparam logic [2:0] PART_RISE = 3'h3;
  localparam logic [2:0] PART_FALL = 3'h4;
  localparam logic [7:0] ADDR_CTRL = 8'h80;
  localparam logic [7:0] ADDR_QUEUE = 8'h84;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h88;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h8c;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h90;
  localparam logic [7:0] ADDR_ROW_MAX = 8'h80;
  // Control register fields.
  localparam int unsigned CTRL_PRESET_BIT = 0;
  localparam int unsigned CTRL_CHAN_LSB = 8;
  localparam int unsigned CTRL_CHAN_BIT = 8;
  // Queue read word: bit 16 set means an entry was present.
  localparam int unsigned QUEUE_VALID_BIT = 16;
  localparam logic [ERRW-1:0] ERR_NONE = 16'h0000;
  localparam logic [WIDTH-1:0] RISE_PRESET = 16'hffff;
  localparam logic [WIDTH-1:0] FALL_PRESET = 16'h0000;
  localparam logic [WIDTH-1:0] ENABLE_PRESET = 16'h0000;
  localparam logic [WIDTH-1:0] ZERO16 = 16'h0000;
  // Interrupt status bits.
  localparam int unsigned IRQ_OPER = 0;
  localparam int unsigned IRQ_QUES = 1;
  localparam int unsigned IRQ_QOVF = 2;
  localparam int unsigned IRQW = 3;
endpackage : ser_pkg

// ---- ser_group.sv ----
// One status group: condition, edge filters, latched events, enable mask and summary.
`timescale 1ns/100ps
module ser_group #(
  parameter int unsigned W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Live condition and software controls
  input wire logic [W-1:0] cond_i,
  input wire logic ev_clear_i,
  input wire logic preset_i,
  input wire logic [W-1:0] preset_en_i,
  input wire logic en_we_i,
  input wire logic rise_we_i,
  input wire logic fall_we_i,
  input wire logic [W-1:0] wdata_i,
  // Contents and summary
  output logic [W-1:0] cond_o,
  output logic [W-1:0] event_o,
  output logic [W-1:0] enable_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o,
  output logic summary_o
);
  typedef struct packed {
    logic [W-1:0] cond;
    logic [W-1:0] ev;
    logic [W-1:0] en;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
    logic sum;
  } ser_grp_st_t;
  ser_grp_st_t st_r;
  ser_grp_st_t st_nxt;
  logic [W-1:0] hit;

  always_comb begin
    st_nxt = st_r;
    st_nxt.cond = cond_i;
    // RULE_12 rising edge detection.
    hit = st_r.rise & ~st_r.cond & cond_i;
    // RULE_11 falling edge detection.
    hit = hit | (st_r.fall & st_r.cond & ~cond_i);
    // RULE_08 read clears events; a new edge in the same cycle survives.
    st_nxt.ev = (ev_clear_i ? ser_pkg::ZERO16 : st_r.ev) | hit;
    if (en_we_i) begin
      st_nxt.en = wdata_i;
    end
    if (rise_we_i) begin
      st_nxt.rise = wdata_i;
    end
    if (fall_we_i) begin
      st_nxt.fall = wdata_i;
    end
    if (preset_i) begin
      // RULE_01 rise filters to all ones.
      st_nxt.rise = ser_pkg::RISE_PRESET;
      // RULE_02 fall filters cleared.
      st_nxt.fall = ser_pkg::FALL_PRESET;
      // RULE_03 enable kept only where preset_en_i is set, cleared elsewhere.
      st_nxt.en = preset_en_i & st_r.en;
    end
    // RULE_14 masked OR summary.
    st_nxt.sum = |(st_nxt.ev & st_nxt.en);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.rise <= ser_pkg::RISE_PRESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cond_o = st_r.cond;
  assign event_o = st_r.ev;
  assign enable_o = st_r.en;
  assign rise_o = st_r.rise;
  assign fall_o = st_r.fall;
  assign summary_o = st_r.sum;

  // RULE_12 rise edge latched
  rise_latch_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_12
    (|(st_r.rise & ~st_r.cond & cond_i)) |=> (|event_o)) else $error("rise edge lost");
  // RULE_11 fall edge latched
  fall_latch_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
    (|(st_r.fall & st_r.cond & ~cond_i)) |=> (|event_o)) else $error("fall edge lost");
  // RULE_09 summary rises with enabled event
  sum_rise_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_09
    (|(hit & enable_o)) && !preset_i && !en_we_i |=> summary_o)
    else $error("summary not set");
  // RULE_08 clear on read
  ev_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
    ev_clear_i && !(|hit) |=> event_o == '0) else $error("event not cleared");
  // RULE_01 preset rise filter
  preset_rise_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
    preset_i |=> rise_o == ser_pkg::RISE_PRESET && fall_o == ser_pkg::FALL_PRESET)
    else $error("preset filters wrong");
  sum_seen_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(summary_o));
endmodule : ser_group

// ---- ser_top.sv ----
// Status event reporting block with error queue and Wishbone register access.
// Notes on behaviour
// RULE_01: Preset loads every rise detect filter with all ones.
// RULE_02: Preset clears every fall detect filter to zero.
// RULE_03: Preset clears enable masks of the two top-level groups.
// RULE_04: Queue read returns newest entry and removes it.
// RULE_05: Empty queue read returns error zero with no-error indication.
// RULE_06: Positive codes are device errors, negative codes protocol errors.
// RULE_07: Condition read returns contents unchanged.
// RULE_08: Event read returns latched bits and clears them.
// RULE_09: Enabled event produces rising summary bit in the higher group; only the active channel's two groups feed the questionable group.
// RULE_10: Software writes only 16-bit mask and filter values.
// RULE_11: Fall filter bit and one-to-zero condition change set event.
// RULE_12: Rise filter bit and zero-to-one condition change set event.
// RULE_13: Channel group access without channel uses the active channel.
// RULE_14: Summary is OR of event bits ANDed with enable bits.
//
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/100ps
module ser_top #(
  parameter int unsigned NCHAN = ser_pkg::NCHAN,
  parameter int unsigned QDEPTH = ser_pkg::QDEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Status conditions from the instrument, per channel for channel groups
  input wire logic [15:0] oper_cond_i,
  input wire logic [15:0] ques_low_cond_i,
  input wire logic [NCHAN*2*16-1:0] chan_cond_i,
  // Error reports
  input wire logic err_push_i,
  input wire logic [15:0] err_code_i,
  // Interrupt
  output logic irq_o
);
  localparam int unsigned NG = 2 + NCHAN * 2;
  localparam int unsigned QA = $clog2(QDEPTH);

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [$clog2(NCHAN)-1:0] chan;
    logic [QDEPTH-1:0][15:0] q;
    logic [QA:0] qcnt;
    logic [ser_pkg::IRQW-1:0] ist;
    logic [ser_pkg::IRQW-1:0] ien;
    logic [ser_pkg::IRQW-1:0] sum_d;
    logic irq;
  } ser_st_t;
  ser_st_t st_r;
  ser_st_t st_nxt;

  logic [NG-1:0][15:0] g_cond;
  logic [NG-1:0][15:0] g_ev;
  logic [NG-1:0][15:0] g_en;
  logic [NG-1:0][15:0] g_rise;
  logic [NG-1:0][15:0] g_fall;
  logic [NG-1:0] g_sum;
  logic [NG-1:0][15:0] g_in;
  logic [NG-1:0] g_clr;
  logic [NG-1:0] g_enwe;
  logic [NG-1:0] g_risewe;
  logic [NG-1:0] g_fallwe;
  logic [15:0] cond_s1;
  logic [15:0] cond_s2;
  logic [15:0] qlow_s1;
  logic [15:0] qlow_s2;
  logic [NCHAN*2*16-1:0] chan_s1;
  logic [NCHAN*2*16-1:0] chan_s2;
  logic req;
  logic wr;
  logic rd;
  logic [2:0] grp_sel;
  logic [2:0] part;
  logic [3:0] gidx;
  logic grp_hit;
  logic preset;
  logic qpop;

  // Conditions come from other logic domains and are synchronised first.
  always_ff @(posedge clk_i) begin
    cond_s1 <= oper_cond_i;
    cond_s2 <= cond_s1;
    qlow_s1 <= ques_low_cond_i;
    qlow_s2 <= qlow_s1;
    chan_s1 <= chan_cond_i;
    chan_s2 <= chan_s1;
  end

  assign req = cyc_i && stb_i && !st_r.ack;
  assign wr = req && we_i && sel_i[0] && sel_i[1];
  assign rd = req && !we_i;
  assign grp_sel = adr_i[7:5];
  assign part = adr_i[4:2];
  // RULE_13 unnamed channel maps to active channel
  assign gidx = (grp_sel < 3'h2) ? {1'b0, grp_sel} :
    4'(2 + 2 * st_r.chan + (grp_sel - 3'h2));
  assign grp_hit = (adr_i < ser_pkg::ADDR_ROW_MAX) && (grp_sel < 3'h4);
  assign preset = wr && adr_i == ser_pkg::ADDR_CTRL && dat_i[ser_pkg::CTRL_PRESET_BIT];
  // RULE_04 queue read pops
  assign qpop = rd && adr_i == ser_pkg::ADDR_QUEUE && st_r.qcnt != '0;

  // Questionable condition collects the active channel summaries into its low bits.
  always_comb begin
    g_in = '0;
    g_in[0] = cond_s2;
    g_in[1] = qlow_s2;
    for (int c = 0; c < NCHAN; c++) begin
      g_in[2 + 2 * c] = chan_s2[c*32 +: 16];
      g_in[3 + 2 * c] = chan_s2[c*32 + 16 +: 16];
    end
    // RULE_09 channel summaries into questionable group
    g_in[1][0] = qlow_s2[0] | g_sum[2 + 2 * st_r.chan];
    g_in[1][1] = qlow_s2[1] | g_sum[3 + 2 * st_r.chan];
  end

  genvar gi;
  generate
    for (gi = 0; gi < NG; gi++) begin : grp_g
      assign g_clr[gi] = rd && grp_hit && gidx == 4'(gi) && part == ser_pkg::PART_EVENT;
      assign g_enwe[gi] = wr && grp_hit && gidx == 4'(gi) && part == ser_pkg::PART_ENABLE;
      assign g_risewe[gi] = wr && grp_hit && gidx == 4'(gi) && part == ser_pkg::PART_RISE;
      assign g_fallwe[gi] = wr && grp_hit && gidx == 4'(gi) && part == ser_pkg::PART_FALL;
      ser_group #(.W(16)) u_grp (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cond_i(g_in[gi]),
        .ev_clear_i(g_clr[gi]),
        .preset_i(preset),
        // RULE_03 only top-level groups lose their masks
        .preset_en_i(gi < 2 ? ser_pkg::ENABLE_PRESET : 16'hffff),
        .en_we_i(g_enwe[gi]),
        .rise_we_i(g_risewe[gi]),
        .fall_we_i(g_fallwe[gi]),
        // RULE_10 only 16 bits are taken
        .wdata_i(dat_i[15:0]),
        .cond_o(g_cond[gi]),
        .event_o(g_ev[gi]),
        .enable_o(g_en[gi]),
        .rise_o(g_rise[gi]),
        .fall_o(g_fall[gi]),
        .summary_o(g_sum[gi])
      );
    end
  endgenerate

  always_comb begin
    logic [ser_pkg::IRQW-1:0] evs;
    evs = '0;
    st_nxt = st_r;
    st_nxt.ack = req;
    st_nxt.dat = '0;
    if (rd) begin
      if (grp_hit) begin
        unique case (part)
          // RULE_07 condition read has no side effect
          ser_pkg::PART_COND: st_nxt.dat = {16'h0000, g_cond[gidx]};
          ser_pkg::PART_EVENT: st_nxt.dat = {16'h0000, g_ev[gidx]};
          ser_pkg::PART_ENABLE: st_nxt.dat = {16'h0000, g_en[gidx]};
          ser_pkg::PART_RISE: st_nxt.dat = {16'h0000, g_rise[gidx]};
          ser_pkg::PART_FALL: st_nxt.dat = {16'h0000, g_fall[gidx]};
          default: st_nxt.dat = '0;
        endcase
      end else if (adr_i == ser_pkg::ADDR_CTRL) begin
        st_nxt.dat = 32'(st_r.chan) << ser_pkg::CTRL_CHAN_LSB;
      end else if (adr_i == ser_pkg::ADDR_QUEUE) begin
        // RULE_05 empty queue gives zero, valid low
        if (st_r.qcnt != '0) begin
          st_nxt.dat = {15'h0000, 1'b1, st_r.q[st_r.qcnt - 1'b1]};
        end else begin
          st_nxt.dat = {16'h0000, ser_pkg::ERR_NONE};
        end
      end else if (adr_i == ser_pkg::ADDR_IRQ_STAT) begin
        st_nxt.dat = 32'(st_r.ist);
      end else if (adr_i == ser_pkg::ADDR_IRQ_EN) begin
        st_nxt.dat = 32'(st_r.ien);
      end
    end
    if (wr && adr_i == ser_pkg::ADDR_CTRL) begin
      st_nxt.chan = dat_i[ser_pkg::CTRL_CHAN_BIT +: $clog2(NCHAN)];
    end
    if (wr && adr_i == ser_pkg::ADDR_IRQ_EN) begin
      st_nxt.ien = dat_i[ser_pkg::IRQW-1:0];
    end
    if (qpop) begin
      st_nxt.qcnt = st_r.qcnt - 1'b1;
    end
    // RULE_06 codes stored as signed two's complement
    if (err_push_i) begin
      if (st_nxt.qcnt == (QA+1)'(QDEPTH)) begin
        // Full queue drops oldest entry so the newest stays readable.
        for (int i = 0; i < QDEPTH - 1; i++) begin
          st_nxt.q[i] = st_r.q[i + 1];
        end
        st_nxt.q[QDEPTH-1] = err_code_i;
        evs[ser_pkg::IRQ_QOVF] = 1'b1;
      end else begin
        st_nxt.q[st_nxt.qcnt[QA-1:0]] = err_code_i;
        st_nxt.qcnt = st_nxt.qcnt + 1'b1;
      end
    end
    st_nxt.sum_d[ser_pkg::IRQ_OPER] = g_sum[0];
    st_nxt.sum_d[ser_pkg::IRQ_QUES] = g_sum[1];
    evs[ser_pkg::IRQ_OPER] = g_sum[0] && !st_r.sum_d[ser_pkg::IRQ_OPER];
    evs[ser_pkg::IRQ_QUES] = g_sum[1] && !st_r.sum_d[ser_pkg::IRQ_QUES];
    // Set wins over clear so no event is lost.
    if (wr && adr_i == ser_pkg::ADDR_IRQ_CLR) begin
      st_nxt.ist = st_r.ist & ~dat_i[ser_pkg::IRQW-1:0];
    end
    st_nxt.ist = st_nxt.ist | evs;
    st_nxt.irq = |(st_nxt.ist & st_nxt.ien);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dat_o = st_r.dat;
  assign ack_o = st_r.ack;
  assign irq_o = st_r.irq;

  // RULE_05 empty queue answer
  empty_queue_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
    rd && adr_i == ser_pkg::ADDR_QUEUE && st_r.qcnt == '0 |=> dat_o == 32'h0)
    else $error("empty queue read not zero");
  // RULE_04 pop removes entry
  queue_pop_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
    qpop && !err_push_i |=> st_r.qcnt == $past(st_r.qcnt) - 1'b1)
    else $error("queue not popped");
  // RULE_04 push adds entry
  queue_push_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
    err_push_i && !qpop && st_r.qcnt != (QA+1)'(QDEPTH)
    |=> st_r.qcnt == $past(st_r.qcnt) + 1'b1)
    else $error("queue push lost");
  // RULE_03 preset clears top masks
  preset_mask_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
    preset |=> g_en[0] == '0 && g_en[1] == '0) else $error("top mask not cleared");
  // RULE_07 condition read keeps events
  cond_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
    rd && grp_hit && part == ser_pkg::PART_COND |-> (g_clr == '0) ##1 ack_o)
    else $error("condition read disturbed events");
  // RULE_08 event read returns latched bits
  event_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
    rd && grp_hit && part == ser_pkg::PART_EVENT |=> dat_o == {16'h0000, $past(g_ev[gidx])})
    else $error("event read data wrong");
  // RULE_09 channel summary reaches questionable group
  chan_summary_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_09
    g_sum[2 + 2 * st_r.chan] |=> g_cond[1][0]) else $error("channel summary lost");
  irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o == |(st_r.ist & st_r.ien)) else $error("irq mismatch");
  pop_seen_c: cover property (@(posedge clk_i) disable iff (rst_i) qpop);
  preset_seen_c: cover property (@(posedge clk_i) disable iff (rst_i) preset);
  irq_seen_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
endmodule : ser_top

// ---- ser_top_test.sv ----
// Self-checking testbench of the status event reporting block.
`timescale 1ns/100ps
module ser_top_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [15:0] oper_cond_i = 16'h0;
  logic [15:0] ques_low_cond_i = 16'h0;
  logic [63:0] chan_cond_i = 64'h0;
  logic err_push_i = 1'b0;
  logic [15:0] err_code_i = 16'h0;
  logic irq_o;
  int errors = 0;
  int samples_checked = 0;
  logic [31:0] rdat;
  logic [15:0] v [0:3];
  logic [15:0] ql;

  ser_top #(.NCHAN(2), .QDEPTH(8)) u_ser_top (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .oper_cond_i(oper_cond_i), .ques_low_cond_i(ques_low_cond_i),
    .chan_cond_i(chan_cond_i), .err_push_i(err_push_i), .err_code_i(err_code_i),
    .irq_o(irq_o)
  );

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  function automatic logic [7:0] ga(input int g, input logic [2:0] p);
    return {g[2:0], p, 2'b00};
  endfunction : ga

  // A queue read word carries the present flag above the code.
  function automatic logic [31:0] qword(input logic [15:0] c);
    return {15'h0, 1'b1, c};
  endfunction : qword

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("BAD at %0t: expected %h got %h", $time, e, g);
    end
  endtask : chk

  // The master never assumes the answer time, so the wait is bounded only by a timeout.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 16);
    rdat = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    if (ack_o !== 1'b1) begin
      errors++;
      end_of_test();
    end
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    wb(1'b1, a, {16'h0, d}, 4'hf);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(e, rdat);
  endtask : rd

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wait_cyc

  task automatic push(input logic [15:0] c);
    @(posedge clk_i);
    err_push_i <= 1'b1;
    err_code_i <= c;
    @(posedge clk_i);
    err_push_i <= 1'b0;
  endtask : push

  task automatic done(input string s);
    $display("test %s finished, mismatches so far %0d", s, errors);
  endtask : done

  initial begin
    void'($urandom(32'h8028cf1f));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int g = 0; g < 4; g++) begin
      v[g] = 16'($urandom);
      wr(ga(g, ser_pkg::PART_ENABLE), v[g]);
      wr(ga(g, ser_pkg::PART_RISE), ~v[g]);
      wr(ga(g, ser_pkg::PART_FALL), v[g]);
    end
    wr(ser_pkg::ADDR_CTRL, 16'h0001);
    for (int g = 0; g < 4; g++) begin
      rd(ga(g, ser_pkg::PART_RISE), 32'h0000ffff);
      rd(ga(g, ser_pkg::PART_FALL), 32'h0);
      rd(ga(g, ser_pkg::PART_ENABLE), (g < 2) ? 32'h0 : {16'h0, v[g]});
    end
    // A write without both low byte lanes must leave the mask alone.
    wb(1'b1, ga(2, ser_pkg::PART_ENABLE), {16'h0, ~v[2]}, 4'h1);
    rd(ga(2, ser_pkg::PART_ENABLE), {16'h0, v[2]});
    done("preset");
    v[0] = 16'($urandom) | 16'h0001;
    oper_cond_i <= v[0];
    wait_cyc(6);
    rd(ga(0, ser_pkg::PART_COND), {16'h0, v[0]});
    rd(ga(0, ser_pkg::PART_COND), {16'h0, v[0]});
    rd(ga(0, ser_pkg::PART_EVENT), {16'h0, v[0]});
    rd(ga(0, ser_pkg::PART_EVENT), 32'h0);
    wr(ga(0, ser_pkg::PART_RISE), 16'h0);
    wr(ga(0, ser_pkg::PART_FALL), 16'hffff);
    oper_cond_i <= 16'h0;
    wait_cyc(6);
    rd(ga(0, ser_pkg::PART_EVENT), {16'h0, v[0]});
    done("edges");
    wr(ser_pkg::ADDR_CTRL, 16'h0001);
    wr(ser_pkg::ADDR_IRQ_CLR, 16'h0007);
    wr(ser_pkg::ADDR_IRQ_EN, 16'h0001);
    wr(ga(0, ser_pkg::PART_ENABLE), 16'h0002);
    oper_cond_i <= 16'h0001;
    wait_cyc(8);
    chk(32'h0, {31'h0, irq_o});
    rd(ga(0, ser_pkg::PART_EVENT), 32'h1);
    oper_cond_i <= 16'h0;
    wr(ga(0, ser_pkg::PART_ENABLE), 16'h0001);
    wait_cyc(6);
    oper_cond_i <= 16'h0001;
    wait_cyc(8);
    chk(32'h1, {31'h0, irq_o});
    rd(ser_pkg::ADDR_IRQ_STAT, 32'h1);
    rd(ser_pkg::ADDR_IRQ_EN, 32'h1);
    rd(ga(0, ser_pkg::PART_EVENT), 32'h1);
    wr(ser_pkg::ADDR_IRQ_CLR, 16'h0001);
    wait_cyc(3);
    chk(32'h0, {31'h0, irq_o});
    done("summary");
    v[1] = 16'($urandom) & 16'h7fff | 16'h0001;
    v[2] = 16'hfffb;
    v[3] = 16'($urandom) & 16'h7fff | 16'h0100;
    for (int i = 1; i < 4; i++) push(v[i]);
    for (int i = 3; i > 0; i--) rd(ser_pkg::ADDR_QUEUE, qword(v[i]));
    rd(ser_pkg::ADDR_QUEUE, 32'h0);
    // Nine pushes into eight places lose the oldest one.
    for (int i = 1; i < 10; i++) push(16'(i));
    for (int i = 9; i > 1; i--) rd(ser_pkg::ADDR_QUEUE, qword(16'(i)));
    rd(ser_pkg::ADDR_QUEUE, 32'h0);
    rd(ser_pkg::ADDR_IRQ_STAT, 32'h4);
    done("queue");
    for (int i = 0; i < 4; i++) v[i] = 16'($urandom);
    v[2] = v[2] | 16'h0001;
    // The low two bits stay clear so that the channel summaries alone decide them.
    ql = 16'($urandom) & 16'hfffc;
    chan_cond_i <= {v[3], v[2], v[1], v[0]};
    ques_low_cond_i <= ql;
    wr(ser_pkg::ADDR_CTRL, 16'h0100);
    rd(ser_pkg::ADDR_CTRL, 32'h00000100);
    wr(ga(2, ser_pkg::PART_ENABLE), 16'h0001);
    wait_cyc(6);
    rd(ga(2, ser_pkg::PART_COND), {16'h0, v[2]});
    rd(ga(3, ser_pkg::PART_COND), {16'h0, v[3]});
    rd(ga(1, ser_pkg::PART_COND), {16'h0, ql | 16'h0001});
    wr(ser_pkg::ADDR_CTRL, 16'h0000);
    rd(ga(3, ser_pkg::PART_COND), {16'h0, v[1]});
    rd(ga(2, ser_pkg::PART_COND), {16'h0, v[0]});
    rd(8'hfc, 32'h0);
    rd(ga(0, 3'h5), 32'h0);
    done("channels");
    end_of_test();
  end
endmodule : ser_top_test
